// [core/input_limit_alarm_trigger.sv]
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Ignore setting passes the value through even outside the range limits.
// - Clamp setting saturates the value at the lower or upper range limit in all modes except digital.
// - Standard limits, current ranges: above 20.1 mA up to 21 mA gives overflow code.
// - Standard limits, current ranges: above 21 mA gives short-circuit code.
// - Standard limits, 4-20 mA: below 3.6 mA gives open-loop code.
// - Standard limits, 4-20 mA: 3.6 to 3.9 mA gives underflow code.
// - Standard limits, 0-2 V: above 2.01 V gives overflow code.
// - Standard limits, 0-10 V: above 10.05 V gives overflow code.
// - Any newly active warning or alarm logs an entry and requests transmission.
// - Digital mode: high input raises warning or alarm as enabled.
// - Endless pulse count mode evaluates no warnings or alarms.
// - Value at or below a lower threshold raises its warning or alarm.
// - Value at or above an upper threshold raises its warning or alarm.
// - Clearing needs the value back past threshold by hysteresis percent.
// - Edge setting picks rising, falling or both edges for edge triggers.
// - Edge trigger actions fire exactly once per trigger event.
// - Level triggers follow the input; actions stay active while set.
// - Edge setting does not affect level triggers.
// - Inversion is applied first, so active-low level triggering works.
// - Triggers exist in all modes except endless pulse count.
module input_limit_alarm_trigger
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire limit_pkg::wb_req_type wb_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire limit_pkg::sample_type sample_i,
   output logic value_valid_o,
   output logic signed [31:0] value_o,
   output logic [2:0] err_code_o,
   output logic warn_o,
   output logic alarm_o,
   output logic log_req_o,
   output logic tx_req_o,
   output logic edge_fire_a_o,
   output logic edge_fire_b_o,
   output logic [5:0] level_hold_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [31:0] ctrl;
      logic [31:0] range_lo;
      logic [31:0] range_hi;
      logic [31:0] warn_lo;
      logic [31:0] warn_hi;
      logic [31:0] alarm_lo;
      logic [31:0] alarm_hi;
      logic [7:0] hyst;
      logic [31:0] trig_en;
      logic [3:0] flags;
      logic warn;
      logic alarm;
      logic prev_src;
      logic valid;
      logic [31:0] value;
      logic [2:0] err;
      logic log_req;
      logic tx_req;
      logic fire_a;
      logic fire_b;
      logic [5:0] hold;
   } state_type;

   state_type s_r;
   state_type s_nxt;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] apply_sel(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            res[8*i +: 8] = dat[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [31:0] margin(input logic [31:0] th, input logic [7:0] h);
      logic [31:0] mag;
      logic [39:0] prod;
      mag = th[31] ? (32'h0000_0000 - th) : th;
      prod = {8'h00, mag} * {32'h0000_0000, h};
      return 32'(prod / limit_pkg::PERCENT);
   endfunction

   function automatic logic beyond(input logic [31:0] v, input logic [31:0] th,
                                   input logic [31:0] m, input logic up);
      logic signed [33:0] sv;
      logic signed [33:0] lim;
      sv = $signed({v[31], v[31], v});
      if (up)
      begin
         lim = $signed({th[31], th[31], th}) + $signed({2'b00, m});
         return sv >= lim;
      end
      lim = $signed({th[31], th[31], th}) - $signed({2'b00, m});
      return sv <= lim;
   endfunction

   // ----------------------------------------
   // Decoded configuration
   // ----------------------------------------
   logic [2:0] mode;
   logic [1:0] rng;
   logic [1:0] edge_sel;
   logic invert;
   logic is_digital;
   logic is_cnt;
   logic is_ma;
   logic signed [31:0] v_in;
   logic lvl;
   logic [31:0] th [4];
   logic [3:0] up_side;

   assign mode = s_r.ctrl[limit_pkg::CTRL_MODE_LSB +: 3];
   assign rng = s_r.ctrl[limit_pkg::CTRL_RANGE_LSB +: 2];
   assign edge_sel = s_r.ctrl[limit_pkg::CTRL_EDGE_LSB +: 2];
   assign invert = s_r.ctrl[limit_pkg::CTRL_INVERT_BIT];
   assign is_digital = mode == limit_pkg::MODE_DIGITAL;
   assign is_cnt = mode == limit_pkg::MODE_CNT_INF;
   assign is_ma = mode == limit_pkg::MODE_MA_0_20 || mode == limit_pkg::MODE_MA_4_20;
   assign v_in = sample_i.value;
   assign lvl = sample_i.level ^ invert;
   assign th[0] = s_r.warn_lo;
   assign th[1] = s_r.warn_hi;
   assign th[2] = s_r.alarm_lo;
   assign th[3] = s_r.alarm_hi;
   assign up_side = 4'hA;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      logic signed [31:0] v;
      logic [2:0] err;
      logic [3:0] fl;
      logic src;
      logic new_ev;
      logic rise;
      logic fall;
      v = v_in;
      err = limit_pkg::ERR_NONE;
      fl = s_r.flags;
      src = 1'b0;
      new_ev = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      s_nxt = s_r;
      s_nxt.valid = 1'b0;
      s_nxt.log_req = 1'b0;
      s_nxt.tx_req = 1'b0;
      s_nxt.fire_a = 1'b0;
      s_nxt.fire_b = 1'b0;

      // Wishbone slave: answer one cycle after request
      s_nxt.ack = wb_i.cyc && wb_i.stb && !s_r.ack;
      s_nxt.rdata = 32'h0000_0000;
      if (wb_i.cyc && wb_i.stb && !s_r.ack)
      begin
         case (wb_i.adr)
            limit_pkg::OFS_CTRL: s_nxt.rdata = s_r.ctrl;
            limit_pkg::OFS_RANGE_LO: s_nxt.rdata = s_r.range_lo;
            limit_pkg::OFS_RANGE_HI: s_nxt.rdata = s_r.range_hi;
            limit_pkg::OFS_WARN_LO: s_nxt.rdata = s_r.warn_lo;
            limit_pkg::OFS_WARN_HI: s_nxt.rdata = s_r.warn_hi;
            limit_pkg::OFS_ALARM_LO: s_nxt.rdata = s_r.alarm_lo;
            limit_pkg::OFS_ALARM_HI: s_nxt.rdata = s_r.alarm_hi;
            limit_pkg::OFS_HYST: s_nxt.rdata = {24'h00_0000, s_r.hyst};
            limit_pkg::OFS_TRIG_EN: s_nxt.rdata = s_r.trig_en;
            limit_pkg::OFS_STATUS: s_nxt.rdata = {16'h0000, s_r.hold, s_r.flags,
                                                  1'b0, s_r.err, s_r.alarm, s_r.warn};
            limit_pkg::OFS_VALUE: s_nxt.rdata = s_r.value;
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end
      if (wb_i.cyc && wb_i.stb && wb_i.we && s_r.ack)
      begin
         case (wb_i.adr)
            limit_pkg::OFS_CTRL: s_nxt.ctrl = apply_sel(s_r.ctrl, wb_i.dat, wb_i.sel);
            limit_pkg::OFS_RANGE_LO: s_nxt.range_lo = apply_sel(s_r.range_lo, wb_i.dat, wb_i.sel);
            limit_pkg::OFS_RANGE_HI: s_nxt.range_hi = apply_sel(s_r.range_hi, wb_i.dat, wb_i.sel);
            limit_pkg::OFS_WARN_LO: s_nxt.warn_lo = apply_sel(s_r.warn_lo, wb_i.dat, wb_i.sel);
            limit_pkg::OFS_WARN_HI: s_nxt.warn_hi = apply_sel(s_r.warn_hi, wb_i.dat, wb_i.sel);
            limit_pkg::OFS_ALARM_LO: s_nxt.alarm_lo = apply_sel(s_r.alarm_lo, wb_i.dat, wb_i.sel);
            limit_pkg::OFS_ALARM_HI: s_nxt.alarm_hi = apply_sel(s_r.alarm_hi, wb_i.dat, wb_i.sel);
            limit_pkg::OFS_HYST:
            begin
               if (wb_i.sel[0])
               begin
                  s_nxt.hyst = wb_i.dat[7:0];
               end
            end
            limit_pkg::OFS_TRIG_EN: s_nxt.trig_en = apply_sel(s_r.trig_en, wb_i.dat, wb_i.sel);
            default: s_nxt.trig_en = s_r.trig_en;
         endcase
      end

      if (sample_i.valid)
      begin
         if (rng == limit_pkg::RNG_CLAMP && !is_digital)
         begin
            if (v_in < $signed(s_r.range_lo))
            begin
               v = $signed(s_r.range_lo);
            end
            else if (v_in > $signed(s_r.range_hi))
            begin
               v = $signed(s_r.range_hi);
            end
         end
         if (rng == limit_pkg::RNG_STANDARD)
         begin
            if (is_ma && v_in > limit_pkg::LIM_SHORT_UA)
            begin
               err = limit_pkg::ERR_SHORT;
            end
            else if (is_ma && v_in > limit_pkg::LIM_OVF_UA)
            begin
               err = limit_pkg::ERR_OVERFLOW;
            end
            else if (mode == limit_pkg::MODE_MA_4_20 && v_in < limit_pkg::LIM_OPEN_UA)
            begin
               err = limit_pkg::ERR_OPEN;
            end
            else if (mode == limit_pkg::MODE_MA_4_20 && v_in <= limit_pkg::LIM_UNDER_UA)
            begin
               err = limit_pkg::ERR_UNDERFLOW;
            end
            else if (mode == limit_pkg::MODE_V_0_2 && v_in > limit_pkg::LIM_OVF_2V_UV)
            begin
               err = limit_pkg::ERR_OVERFLOW;
            end
            else if (mode == limit_pkg::MODE_V_0_10 && v_in > limit_pkg::LIM_OVF_10V_UV)
            begin
               err = limit_pkg::ERR_OVERFLOW;
            end
         end
         s_nxt.valid = 1'b1;
         s_nxt.err = err;
         // Value kept unless an error code is set; then value reads zero
         s_nxt.value = (err == limit_pkg::ERR_NONE) ? v : 32'h0000_0000;

         // Flags: warn_lo, warn_hi, alarm_lo, alarm_hi
         if (is_cnt)
         begin
            fl = 4'h0;
         end
         else if (is_digital)
         begin
            fl = {1'b0, lvl && s_r.ctrl[limit_pkg::CTRL_DALARM_BIT],
                  1'b0, lvl && s_r.ctrl[limit_pkg::CTRL_DWARN_BIT]};
         end
         else
         begin
            for (int i = 0; i < 4; i++)
            begin
               if (up_side[i] ? (v >= $signed(th[i])) : (v <= $signed(th[i])))
               begin
                  fl[i] = 1'b1;
               end
               else if (beyond(v, th[i], margin(th[i], s_r.hyst), !up_side[i]))
               begin
                  fl[i] = 1'b0;
               end
            end
         end
         s_nxt.flags = fl;
         s_nxt.warn = fl[0] || fl[1];
         s_nxt.alarm = fl[2] || fl[3];
         // Log and transmit on new event
         new_ev = (s_nxt.warn && !s_r.warn) || (s_nxt.alarm && !s_r.alarm);
         s_nxt.log_req = new_ev;
         s_nxt.tx_req = new_ev;

         src = is_digital ? lvl : (s_nxt.warn || s_nxt.alarm);
         src = src && !is_cnt;
         s_nxt.prev_src = src;
         rise = src && !s_r.prev_src;
         fall = !src && s_r.prev_src && !is_cnt;
         if ((edge_sel == limit_pkg::EDGE_RISING && rise) ||
             (edge_sel == limit_pkg::EDGE_FALLING && fall) ||
             (edge_sel == limit_pkg::EDGE_BOTH && (rise || fall)))
         begin
            s_nxt.fire_a = s_r.trig_en[0];
            s_nxt.fire_b = s_r.trig_en[1];
         end
         s_nxt.hold = {6{src}} & s_r.trig_en[limit_pkg::TRIG_LEVEL_LSB +: 6];
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_r <= '0;
         s_r.ctrl <= limit_pkg::CTRL_RST;
         s_r.range_lo <= limit_pkg::LIMIT_RST;
         s_r.range_hi <= limit_pkg::LIMIT_RST;
         s_r.hyst <= limit_pkg::HYST_RST;
         s_r.trig_en <= limit_pkg::TRIG_EN_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = s_r.rdata;
   assign value_valid_o = s_r.valid;
   assign value_o = s_r.value;
   assign err_code_o = s_r.err;
   assign warn_o = s_r.warn;
   assign alarm_o = s_r.alarm;
   assign log_req_o = s_r.log_req;
   assign tx_req_o = s_r.tx_req;
   assign edge_fire_a_o = s_r.fire_a;
   assign edge_fire_b_o = s_r.fire_b;
   assign level_hold_o = s_r.hold;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic std_ma;
   assign std_ma = sample_i.valid && rng == limit_pkg::RNG_STANDARD && is_ma;

   property p_ignore_pass;
      sample_i.valid && rng == limit_pkg::RNG_IGNORE && !is_digital
         |=> value_o == $past(sample_i.value) && err_code_o == limit_pkg::ERR_NONE;
   endproperty
   a_ignore_pass: assert property (p_ignore_pass) else $error("ignore value changed");

   property p_clamp_range;
      sample_i.valid && rng == limit_pkg::RNG_CLAMP && !is_digital && !wb_i.we
         |=> value_valid_o && value_o <= $signed(s_r.range_hi) && value_o >= $signed(s_r.range_lo);
   endproperty
   a_clamp_range: assert property (p_clamp_range) else $error("clamp out of range");

   property p_overflow_ma;
      std_ma && v_in > limit_pkg::LIM_OVF_UA && v_in <= limit_pkg::LIM_SHORT_UA
         |=> err_code_o == limit_pkg::ERR_OVERFLOW;
   endproperty
   a_overflow_ma: assert property (p_overflow_ma) else $error("overflow code missing");

   property p_short_ma;
      std_ma && v_in > limit_pkg::LIM_SHORT_UA |=> err_code_o == limit_pkg::ERR_SHORT;
   endproperty
   a_short_ma: assert property (p_short_ma) else $error("short code missing");

   property p_open_loop;
      std_ma && mode == limit_pkg::MODE_MA_4_20 && v_in < limit_pkg::LIM_OPEN_UA
         |=> err_code_o == limit_pkg::ERR_OPEN;
   endproperty
   a_open_loop: assert property (p_open_loop) else $error("open loop code missing");

   property p_event_log;
      value_valid_o && ($rose(warn_o) || $rose(alarm_o)) |-> log_req_o && tx_req_o;
   endproperty
   a_event_log: assert property (p_event_log) else $error("event not logged");

   property p_cnt_quiet;
      sample_i.valid && is_cnt |=> !warn_o && !alarm_o && level_hold_o == 6'h00;
   endproperty
   a_cnt_quiet: assert property (p_cnt_quiet) else $error("pulse count mode evaluated");

   property p_alarm_low;
      sample_i.valid && !is_digital && !is_cnt && rng == limit_pkg::RNG_IGNORE
         && v_in <= $signed(s_r.alarm_lo) |=> alarm_o;
   endproperty
   a_alarm_low: assert property (p_alarm_low) else $error("low alarm missing");

   property p_fire_once;
      edge_fire_a_o |=> !edge_fire_a_o;
   endproperty
   a_fire_once: assert property (p_fire_once) else $error("edge action repeated");

   property p_level_follow;
      sample_i.valid && is_digital && s_r.trig_en[limit_pkg::TRIG_LEVEL_LSB] && !wb_i.we
         |=> level_hold_o[0] == ($past(sample_i.level) ^ invert);
   endproperty
   a_level_follow: assert property (p_level_follow) else $error("level hold wrong");

   c_short: cover property (value_valid_o && err_code_o == limit_pkg::ERR_SHORT);
   c_alarm: cover property ($rose(alarm_o) ##[1:50] $fell(alarm_o));
   c_fire: cover property (edge_fire_a_o);
   c_hold: cover property (level_hold_o[0] [*3]);

endmodule

`default_nettype wire

// [core/limit_pkg.sv]
`default_nettype none

package limit_pkg;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_RANGE_LO = 8'h04;
   localparam logic [7:0] OFS_RANGE_HI = 8'h08;
   localparam logic [7:0] OFS_WARN_LO = 8'h0C;
   localparam logic [7:0] OFS_WARN_HI = 8'h10;
   localparam logic [7:0] OFS_ALARM_LO = 8'h14;
   localparam logic [7:0] OFS_ALARM_HI = 8'h18;
   localparam logic [7:0] OFS_HYST = 8'h1C;
   localparam logic [7:0] OFS_TRIG_EN = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_VALUE = 8'h28;

   // ----------------------------------------
   // Control fields and reset values
   // ----------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_RANGE_LSB = 4;
   localparam int CTRL_EDGE_LSB = 8;
   localparam int CTRL_INVERT_BIT = 12;
   localparam int CTRL_DWARN_BIT = 16;
   localparam int CTRL_DALARM_BIT = 17;
   localparam int TRIG_LEVEL_LSB = 8;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] LIMIT_RST = 32'h0000_0000;
   localparam logic [7:0] HYST_RST = 8'h00;
   localparam logic [31:0] TRIG_EN_RST = 32'h0000_0000;

   // ----------------------------------------
   // Modes, range handling, edges, error codes
   // ----------------------------------------
   localparam logic [2:0] MODE_DIGITAL = 3'h0;
   localparam logic [2:0] MODE_CNT_INF = 3'h1;
   localparam logic [2:0] MODE_MA_0_20 = 3'h2;
   localparam logic [2:0] MODE_MA_4_20 = 3'h3;
   localparam logic [2:0] MODE_V_0_2 = 3'h4;
   localparam logic [2:0] MODE_V_0_10 = 3'h5;
   localparam logic [1:0] RNG_IGNORE = 2'h0;
   localparam logic [1:0] RNG_CLAMP = 2'h1;
   localparam logic [1:0] RNG_STANDARD = 2'h2;
   localparam logic [1:0] EDGE_RISING = 2'h0;
   localparam logic [1:0] EDGE_FALLING = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   localparam logic [2:0] ERR_NONE = 3'h0;
   localparam logic [2:0] ERR_OVERFLOW = 3'h1;
   localparam logic [2:0] ERR_SHORT = 3'h2;
   localparam logic [2:0] ERR_OPEN = 3'h3;
   localparam logic [2:0] ERR_UNDERFLOW = 3'h4;

   // ----------------------------------------
   // Standard limits: currents in uA, voltages in uV
   // ----------------------------------------
   localparam logic signed [31:0] LIM_OVF_UA = 32'sh0000_4E84;
   localparam logic signed [31:0] LIM_SHORT_UA = 32'sh0000_5208;
   localparam logic signed [31:0] LIM_OPEN_UA = 32'sh0000_0E10;
   localparam logic signed [31:0] LIM_UNDER_UA = 32'sh0000_0F3C;
   localparam logic signed [31:0] LIM_OVF_2V_UV = 32'sh001E_AB90;
   localparam logic signed [31:0] LIM_OVF_10V_UV = 32'sh0099_59D0;
   localparam logic [39:0] PERCENT = 40'h00_0000_0064;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_type;

   typedef struct packed {
      logic valid;
      logic signed [31:0] value;
      logic level;
   } sample_type;

endpackage

`default_nettype wire

// [sim/input_limit_alarm_trigger_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module input_limit_alarm_trigger_tb;
   logic clk_i;
   logic rst_i;
   limit_pkg::wb_req_type wb_i;
   logic wb_ack_o;
   logic [31:0] wb_dat_o;
   limit_pkg::sample_type sample_i;
   logic value_valid_o;
   logic signed [31:0] value_o;
   logic [2:0] err_code_o;
   logic warn_o;
   logic alarm_o;
   logic log_req_o;
   logic tx_req_o;
   logic edge_fire_a_o;
   logic edge_fire_b_o;
   logic [5:0] level_hold_o;
   int n_errors;
   int tests_run;
   logic [31:0] rd;
   logic [2:0] t_mode [0:9];
   logic signed [31:0] t_val [0:9];
   logic [2:0] t_err [0:9];

   input_limit_alarm_trigger dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .sample_i(sample_i),
      .value_valid_o(value_valid_o), .value_o(value_o), .err_code_o(err_code_o),
      .warn_o(warn_o), .alarm_o(alarm_o), .log_req_o(log_req_o), .tx_req_o(tx_req_o),
      .edge_fire_a_o(edge_fire_a_o), .edge_fire_b_o(edge_fire_b_o),
      .level_hold_o(level_hold_o));

   sensor_model sensor_u (.clk_i(clk_i), .sample_o(sample_i));

   // ----------------------------------------
   // Clock and helpers
   // ----------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   task automatic summarize();
      $display("Compares %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
      for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++)
         @(posedge clk_i);
      if (wb_ack_o !== 1'b1)
      begin
         n_errors++;
         summarize();
      end
      rd = wb_dat_o;
      wb_i <= '0;
   endtask

   task automatic smp(input logic signed [31:0] v, input logic lvl);
      sensor_u.put(v, lvl);
      #1;
   endtask

   function automatic logic [31:0] cfg(logic [2:0] m, logic [1:0] r, logic [1:0] e,
      logic inv, logic w, logic a);
      return ({29'h0, m} << limit_pkg::CTRL_MODE_LSB) | ({30'h0, r} << 4) |
         ({30'h0, e} << 8) | ({31'h0, inv} << 12) | ({31'h0, w} << 16) | ({31'h0, a} << 17);
   endfunction

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      n_errors = 0;
      tests_run = 0;
      wb_i = '0;
      rst_i = 1'b1;
      t_mode = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h5};
      t_val = '{20100, 20101, 21000, 21001, 3599, 3600, 3900, 3901, 2010001, 10050001};
      t_err = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h0, 3'h1, 3'h1};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, limit_pkg::OFS_CTRL, 32'h0);
      chk(rd, limit_pkg::CTRL_RST);
      wb(1'b0, limit_pkg::OFS_HYST, 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, 8'h40, 32'hFFFF_FFFF);
      wb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      $display("Test registers done");
      wb(1'b1, limit_pkg::OFS_RANGE_HI, 32'd1000);
      wb(1'b1, limit_pkg::OFS_CTRL, cfg(limit_pkg::MODE_MA_0_20, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0));
      smp(5000, 1'b0);
      chk(value_o, 32'd5000);
      chk(value_valid_o, 32'h1);
      wb(1'b1, limit_pkg::OFS_CTRL, cfg(limit_pkg::MODE_MA_0_20, 2'h1, 2'h0, 1'b0, 1'b0, 1'b0));
      smp(5000, 1'b0);
      chk(value_o, 32'd1000);
      smp(-5, 1'b0);
      chk(value_o, 32'h0);
      $display("Test range handling done");
      for (int k = 0; k < 10; k++)
      begin
         wb(1'b1, limit_pkg::OFS_CTRL, cfg(t_mode[k], 2'h2, 2'h0, 1'b0, 1'b0, 1'b0));
         smp(t_val[k], 1'b0);
         chk({29'h0, err_code_o}, {29'h0, t_err[k]});
      end
      $display("Test standard limits done");
      wb(1'b1, limit_pkg::OFS_CTRL, cfg(limit_pkg::MODE_MA_0_20, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0));
      wb(1'b1, limit_pkg::OFS_WARN_HI, 32'd1000);
      wb(1'b1, limit_pkg::OFS_WARN_LO, 32'hFFFF_FC18);
      wb(1'b1, limit_pkg::OFS_ALARM_HI, 32'd5000);
      wb(1'b1, limit_pkg::OFS_ALARM_LO, 32'd100);
      wb(1'b1, limit_pkg::OFS_HYST, 32'd10);
      smp(500, 1'b0);
      chk({warn_o, alarm_o}, 32'h0);
      smp(1000, 1'b0);
      chk({warn_o, alarm_o, log_req_o, tx_req_o}, 32'hB);
      smp(950, 1'b0);
      chk({warn_o, log_req_o}, 32'h2);
      smp(900, 1'b0);
      chk(warn_o, 32'h0);
      smp(100, 1'b0);
      chk({alarm_o, log_req_o, tx_req_o}, 32'h7);
      wb(1'b0, limit_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h0000_0102);
      $display("Test thresholds done");
      wb(1'b1, limit_pkg::OFS_TRIG_EN, 32'h0000_3F03);
      wb(1'b1, limit_pkg::OFS_CTRL, cfg(limit_pkg::MODE_DIGITAL, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0));
      smp(0, 1'b0);
      chk({warn_o, edge_fire_a_o}, 32'h0);
      smp(0, 1'b1);
      chk({warn_o, alarm_o, edge_fire_a_o, level_hold_o[0]}, 32'hB);
      chk({edge_fire_b_o, level_hold_o}, 32'h7F);
      smp(0, 1'b1);
      chk({edge_fire_a_o, edge_fire_b_o, level_hold_o}, 32'h3F);
      smp(0, 1'b0);
      chk({edge_fire_a_o, level_hold_o[0]}, 32'h0);
      wb(1'b1, limit_pkg::OFS_CTRL, cfg(limit_pkg::MODE_DIGITAL, 2'h0, 2'h1, 1'b0, 1'b0, 1'b1));
      smp(0, 1'b1);
      chk({alarm_o, warn_o, edge_fire_a_o, level_hold_o[0]}, 32'h9);
      smp(0, 1'b0);
      chk({edge_fire_a_o, edge_fire_b_o, level_hold_o[0]}, 32'h6);
      wb(1'b1, limit_pkg::OFS_CTRL, cfg(limit_pkg::MODE_DIGITAL, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0));
      smp(0, 1'b0);
      chk(level_hold_o[0], 32'h1);
      smp(0, 1'b1);
      chk(level_hold_o[0], 32'h0);
      wb(1'b1, limit_pkg::OFS_CTRL, cfg(limit_pkg::MODE_CNT_INF, 2'h0, 2'h2, 1'b0, 1'b1, 1'b1));
      smp(0, 1'b1);
      smp(0, 1'b0);
      chk({warn_o, alarm_o, edge_fire_a_o, level_hold_o}, 32'h0);
      $display("Test triggers done");
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, limit_pkg::OFS_CTRL, 32'h0);
      chk(rd, limit_pkg::CTRL_RST);
      wb(1'b0, limit_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
      $display("Test reset done");
      summarize();
   end

endmodule

`default_nettype wire

// [sim/sensor_model.sv]
`timescale 1ns/1ps
`default_nettype none

module sensor_model
(
   input wire logic clk_i,
   output var limit_pkg::sample_type sample_o
);

   // ----------------------------------------
   // Sample source with one-cycle strobe
   // ----------------------------------------
   initial
   begin
      sample_o = '0;
   end

   // Value line is scrambled once the strobe drops
   task automatic put(input logic signed [31:0] v, input logic lvl);
      @(posedge clk_i);
      sample_o <= '{valid: 1'b1, value: v, level: lvl};
      @(posedge clk_i);
      sample_o.valid <= 1'b0;
      sample_o.value <= ~v;
   endtask

endmodule

`default_nettype wire
